// File: rtl/seq_pkg.sv
// Purpose: Shared constants and state type for the dual-integrator sequencer
// Assumes: Core clock of 20 MHz; the sequence timing figures below are counted in core clock periods
// Notes:   Long counts are only defaults; the top module takes them as parameters
package seq_pkg;

	localparam int CORE_CLK_PERIOD_NS = 50;

	// Slow clock is the core clock divided by this ratio
	localparam int SLOW_DIV_RATIO = 6;
	localparam int SLOW_DIV_W     = 3;

	// Sequence timing in core clock periods
	localparam int MRAZ_CONT_CLKS   = 4794;
	localparam int RESULT1_CLKS     = 4212;
	localparam int MRAZ_GAP_CLKS    = 9108;
	localparam int RESULT2_GAP_CLKS = 4548;
	localparam int PREP_MIN_CLKS    = 240;

	// Eight sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_MRAZ_A_FIRST = 8'h01,
		ST_PREP_A       = 8'h02,
		ST_INT_A        = 8'h04,
		ST_INT_B_MRAZ_A = 8'h08,
		ST_INT_A_MRAZ_B = 8'h10,
		ST_INT_B        = 8'h20,
		ST_PREP_B       = 8'h40,
		ST_MRAZ_B_FIRST = 8'h80
	} seq_state_e;

endpackage

// File: rtl/slow_clock_divider.sv
// Purpose: Divide the core clock into the slow clock that paces measurement
// Assumes: run is a registered level from the sequencer
// Notes:   Held in phase zero while run is low, so each restart is aligned to run
`timescale 1ns/1ps
module slow_clock_divider #(
	parameter int DIV = seq_pkg::SLOW_DIV_RATIO
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic run,
	output logic      slow_tick,
	output logic      slow_clk
);

	logic [seq_pkg::SLOW_DIV_W-1:0] cnt_ff;
	logic [seq_pkg::SLOW_DIV_W-1:0] nxt_cnt;
	logic                           slow_clk_ff;

	generate
		if (DIV < 2 || DIV > (1 << seq_pkg::SLOW_DIV_W)) begin : bad_div
			$error("slow_clock_divider: DIV out of range");
		end
	endgenerate

	always_comb begin
		if (!run) begin
			nxt_cnt = '0;
		end else if (cnt_ff == seq_pkg::SLOW_DIV_W'(DIV - 1)) begin
			nxt_cnt = '0;
		end else begin
			nxt_cnt = cnt_ff + seq_pkg::SLOW_DIV_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= '0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Stopping resets the phase; this is what re-aligns the slow clock to the select input
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slow_clk_ff <= 1'b0;
		end else if (ce) begin
			slow_clk_ff <= run && (nxt_cnt >= seq_pkg::SLOW_DIV_W'(DIV / 2));
		end
	end

	assign slow_tick = run && (cnt_ff == seq_pkg::SLOW_DIV_W'(DIV - 1));
	assign slow_clk  = slow_clk_ff;

endmodule // slow_clock_divider

// File: rtl/dual_integrator_sequencer.sv
// Purpose: Sequencer choosing which integrator side integrates and which is measured
// Assumes: integration_select and transmit_request_n are synchronous to core_clk
// Notes:   Measurement timing runs on slow clock ticks; long counts are parameters
//
// Functional notes
// - Power-up into state 1 or 8 by select
// - Gapless operation alternates states 4 and 5
// - Ready low until transmit request goes low
// - Gapped pairs; no state 3/6 while busy
// - States 1 and 8 wait out busy only
// - State 2 to 3 once select high
// - Gapped first ready as gapless; second fixed
// - Early end measures A then B from 4, B then A from 5; integration resumes
// - First gapless integration may be short
// - Slow clock is core clock divided by six
// - Gapless: slow clock stops after measurement
// - Gapped: slow clock runs without gating
// - Slow clock restart re-aligns to select toggle
// - Second gapped ready timed from first, no jitter
// - Side A integrates on high, B on low
// - Gapless measure 4794, ready after 4212
// - Gapped measure 9108, preparation 240 minimum; not enforced here, the host times it
// - Second gapped ready 4548 after first
`timescale 1ns/1ps
module dual_integrator_sequencer #(
	parameter int MRAZ_CONT_CLKS   = seq_pkg::MRAZ_CONT_CLKS,
	parameter int RESULT1_CLKS     = seq_pkg::RESULT1_CLKS,
	parameter int MRAZ_GAP_CLKS    = seq_pkg::MRAZ_GAP_CLKS,
	parameter int RESULT2_GAP_CLKS = seq_pkg::RESULT2_GAP_CLKS
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic         integration_select,
	input  wire logic         transmit_request_n,
	output logic              result_ready_n,
	output seq_pkg::seq_state_e state,
	output logic              side_a_integrating,
	output logic              side_b_integrating,
	output logic              input_grounded,
	output logic              measure_busy,
	output logic              gapped_mode,
	output logic              slow_clk
);

	localparam int DIV       = seq_pkg::SLOW_DIV_RATIO;
	localparam int CONT_TK   = MRAZ_CONT_CLKS / DIV;
	localparam int GAP_TK    = MRAZ_GAP_CLKS / DIV;
	localparam int RES1_TK   = RESULT1_CLKS / DIV;
	localparam int RES2_TK   = RES1_TK + RESULT2_GAP_CLKS / DIV;
	localparam int TK_W      = $clog2(GAP_TK + 1);

	generate
		if ((MRAZ_CONT_CLKS % DIV) != 0 || (MRAZ_GAP_CLKS % DIV) != 0 ||
			(RESULT1_CLKS % DIV) != 0 || (RESULT2_GAP_CLKS % DIV) != 0) begin : bad_multiple
			$error("dual_integrator_sequencer: counts must be multiples of the divide ratio");
		end
		if (RES1_TK < 1 || RES1_TK >= CONT_TK || RES2_TK >= GAP_TK ||
			CONT_TK >= GAP_TK) begin : bad_order
			$error("dual_integrator_sequencer: timing counts out of order");
		end
	endgenerate

	seq_pkg::seq_state_e state_ff;
	seq_pkg::seq_state_e nxt_state;
	logic                started_ff;
	logic                busy_ff;
	logic                pair_ff;
	logic [TK_W-1:0]     elapsed_ff;
	logic [TK_W-1:0]     elapsed_inc;
	logic                gapped_ff;
	logic                ready_n_ff;
	logic                slow_tick;
	logic                start_mraz;
	logic                extend_pair;
	logic                enter_gapless;
	logic                ready_event;
	logic                mraz_done;

	// Next state follows select level and busy, never select edges
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			seq_pkg::ST_MRAZ_A_FIRST: begin
				if (!busy_ff) nxt_state = seq_pkg::ST_PREP_A;
			end
			seq_pkg::ST_PREP_A: begin
				// No minimum stay: the host owns the preparation time
				if (integration_select) nxt_state = seq_pkg::ST_INT_A;
			end
			seq_pkg::ST_INT_A: begin
				if (!integration_select) nxt_state = seq_pkg::ST_INT_B_MRAZ_A;
			end
			seq_pkg::ST_INT_B_MRAZ_A: begin
				if (integration_select) begin
					nxt_state = busy_ff ? seq_pkg::ST_MRAZ_A_FIRST
					                    : seq_pkg::ST_INT_A_MRAZ_B;
				end
			end
			seq_pkg::ST_INT_A_MRAZ_B: begin
				if (!integration_select) begin
					nxt_state = busy_ff ? seq_pkg::ST_MRAZ_B_FIRST
					                    : seq_pkg::ST_INT_B_MRAZ_A;
				end
			end
			seq_pkg::ST_INT_B: begin
				if (integration_select) nxt_state = seq_pkg::ST_INT_A_MRAZ_B;
			end
			seq_pkg::ST_PREP_B: begin
				if (!integration_select) nxt_state = seq_pkg::ST_INT_B;
			end
			seq_pkg::ST_MRAZ_B_FIRST: begin
				if (!busy_ff) nxt_state = seq_pkg::ST_PREP_B;
			end
			default: nxt_state = seq_pkg::ST_MRAZ_A_FIRST;
		endcase
	end

	// An integration ending with the other side idle starts a measurement
	assign start_mraz = (state_ff != nxt_state) &&
		(state_ff == seq_pkg::ST_INT_A || state_ff == seq_pkg::ST_INT_B ||
		 nxt_state == seq_pkg::ST_INT_A_MRAZ_B || nxt_state == seq_pkg::ST_INT_B_MRAZ_A);
	// Ending an integration while busy folds both sides into one long measurement
	assign extend_pair = (state_ff != nxt_state) &&
		(nxt_state == seq_pkg::ST_MRAZ_A_FIRST || nxt_state == seq_pkg::ST_MRAZ_B_FIRST);
	assign enter_gapless = (state_ff != nxt_state) &&
		(state_ff == seq_pkg::ST_INT_A_MRAZ_B || state_ff == seq_pkg::ST_INT_B_MRAZ_A) &&
		!busy_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			started_ff <= 1'b0;
			state_ff   <= seq_pkg::ST_MRAZ_A_FIRST;
		end else if (ce) begin
			started_ff <= 1'b1;
			if (!started_ff) begin
				state_ff <= integration_select ? seq_pkg::ST_MRAZ_A_FIRST
				                               : seq_pkg::ST_MRAZ_B_FIRST;
			end else begin
				state_ff <= nxt_state;
			end
		end
	end

	assign elapsed_inc = elapsed_ff + TK_W'(1);
	assign mraz_done   = slow_tick && busy_ff &&
		(elapsed_inc == (pair_ff ? TK_W'(GAP_TK) : TK_W'(CONT_TK)));

	// Measurement engine paced by slow ticks
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy_ff    <= 1'b0;
			pair_ff    <= 1'b0;
			elapsed_ff <= '0;
		end else if (ce && started_ff) begin
			if (start_mraz) begin
				busy_ff    <= 1'b1;
				pair_ff    <= 1'b0;
				elapsed_ff <= '0;
			end else begin
				if (extend_pair) pair_ff <= 1'b1;
				if (slow_tick && busy_ff) elapsed_ff <= elapsed_inc;
				if (mraz_done) busy_ff <= 1'b0;
			end
		end
	end

	// Second result counts from the first on the same slow clock, so it carries no jitter
	assign ready_event = slow_tick && busy_ff &&
		(elapsed_inc == TK_W'(RES1_TK) ||
		 (pair_ff && elapsed_inc == TK_W'(RES2_TK)));

	// Set wins over the host's request so a result is never lost
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ready_n_ff <= 1'b1;
		end else if (ce) begin
			if (ready_event) begin
				ready_n_ff <= 1'b0;
			end else if (!transmit_request_n) begin
				ready_n_ff <= 1'b1;
			end
		end
	end

	// Gapped from power-up or any folded pair until a clean 4/5 swap
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gapped_ff <= 1'b1;
		end else if (ce && started_ff) begin
			if (extend_pair) begin
				gapped_ff <= 1'b1;
			end else if (enter_gapless) begin
				gapped_ff <= 1'b0;
			end
		end
	end

	// Gating trades continuous pacing for a fixed edge count per integration
	slow_clock_divider #(
		.DIV (DIV)
	) u_slow_clock_divider (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.ce        (ce),
		.run       (busy_ff || gapped_ff),
		.slow_tick (slow_tick),
		.slow_clk  (slow_clk)
	);

	assign side_a_integrating = (state_ff == seq_pkg::ST_INT_A) ||
	                            (state_ff == seq_pkg::ST_INT_A_MRAZ_B);
	assign side_b_integrating = (state_ff == seq_pkg::ST_INT_B) ||
	                            (state_ff == seq_pkg::ST_INT_B_MRAZ_A);
	assign input_grounded     = !(side_a_integrating || side_b_integrating);
	assign result_ready_n     = ready_n_ff;
	assign state              = state_ff;
	assign measure_busy       = busy_ff;
	assign gapped_mode        = gapped_ff;

endmodule // dual_integrator_sequencer

// File: bench/seq_asserts.sv
// Purpose: Port checks for the sequencer
// Assumes: ce held high by the bench
// Notes:   Ready window covers the divider phase when not resynchronised
`timescale 1ns/1ps
module seq_asserts #(
	parameter int RESULT1_CLKS = 42
) (
	input wire logic                core_clk,
	input wire logic                resetn,
	input wire logic                integration_select,
	input wire logic                transmit_request_n,
	input wire logic                result_ready_n,
	input wire seq_pkg::seq_state_e state,
	input wire logic                measure_busy,
	input wire logic                gapped_mode,
	input wire logic                slow_clk
);
	// A free-running divider can only bring the first ready earlier, by under one slow period
	localparam int R_LO = RESULT1_CLKS - 5;
	localparam int R_HI = RESULT1_CLKS;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_wait_out_busy: assert property (measure_busy &&
		(state inside {seq_pkg::ST_MRAZ_A_FIRST, seq_pkg::ST_MRAZ_B_FIRST})
		|=> $stable(state)) else $error("first state left while busy");
	a_prep_a_go: assert property (state == seq_pkg::ST_PREP_A && integration_select
		|=> state == seq_pkg::ST_INT_A) else $error("no move from prep A");
	a_gapless_swap: assert property (state == seq_pkg::ST_INT_B_MRAZ_A && !measure_busy
		&& integration_select |=> state == seq_pkg::ST_INT_A_MRAZ_B) else $error("no swap");
	a_no_int_busy: assert property (measure_busy
		|-> !(state inside {seq_pkg::ST_INT_A, seq_pkg::ST_INT_B})) else $error("lone int busy");
	a_ready_holds: assert property (!result_ready_n && transmit_request_n
		|=> !result_ready_n) else $error("ready dropped early");
	a_ready_frees: assert property (!result_ready_n && !transmit_request_n
		|=> result_ready_n) else $error("ready not released");
	a_gap_slow_run: assert property ($rose(slow_clk) && gapped_mode
		|-> ##6 $rose(slow_clk)) else $error("slow clock not period six");
	a_slow_stops: assert property ((!gapped_mode && !measure_busy)[*2]
		|=> !slow_clk) else $error("slow clock not stopped");
	a_ready_delay: assert property ($rose(measure_busy)
		|-> ##[R_LO:R_HI] $fell(result_ready_n)) else $error("ready delay off");
endmodule // seq_asserts
bind dual_integrator_sequencer seq_asserts #(.RESULT1_CLKS(RESULT1_CLKS)) u_chk (
	.core_clk(core_clk), .resetn(resetn), .integration_select(integration_select),
	.transmit_request_n(transmit_request_n), .result_ready_n(result_ready_n),
	.state(state), .measure_busy(measure_busy), .gapped_mode(gapped_mode),
	.slow_clk(slow_clk));

// File: bench/ready_host.sv
// Purpose: Host side answering the ready strobe
// Assumes: Runs on the core clock
// Notes:   LAG sets how slowly the host reacts
`timescale 1ns/1ps
module ready_host #(
	parameter int LAG = 2
) (
	input  wire logic core_clk,
	input  wire logic result_ready_n,
	output logic      transmit_request_n
);
	int cnt = 0;
	initial transmit_request_n = 1'b1;
	// Polls the strobe rather than timing from the select toggle
	always @(posedge core_clk) begin
		if (result_ready_n) begin
			cnt <= 0;
			transmit_request_n <= 1'b1;
		end else if (cnt == LAG) begin
			transmit_request_n <= 1'b0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // ready_host

// File: bench/dual_integrator_sequencer_bench.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Small timing parameters, prompt host
// Notes:   Delays compared with each other to cancel sampling offsets
`timescale 1ns/1ps
module dual_integrator_sequencer_bench;
	localparam int MC = 60;
	localparam int MG = 120;
	localparam int R2 = 48;
	logic core_clk = 0, resetn = 0, ce = 1, integration_select = 1, rq = 1, sq = 0;
	logic transmit_request_n, result_ready_n, busy, gm, slow_clk, sa, sb, gnd;
	seq_pkg::seq_state_e state;
	int cyc = 0, fall_t = 0, fall_p = 0, bcnt = 0, srise = 0;
	int mismatches = 0, samples_checked = 0;
	always #25 core_clk = ~core_clk;
	dual_integrator_sequencer #(.MRAZ_CONT_CLKS(MC), .RESULT1_CLKS(42),
		.MRAZ_GAP_CLKS(MG), .RESULT2_GAP_CLKS(R2)) DUT (.core_clk(core_clk),
		.resetn(resetn), .ce(ce), .integration_select(integration_select),
		.transmit_request_n(transmit_request_n), .result_ready_n(result_ready_n),
		.state(state), .side_a_integrating(sa), .side_b_integrating(sb),
		.input_grounded(gnd), .measure_busy(busy), .gapped_mode(gm), .slow_clk(slow_clk));
	ready_host #(.LAG(2)) host (.core_clk(core_clk), .result_ready_n(result_ready_n),
		.transmit_request_n(transmit_request_n));
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		rq <= result_ready_n;
		sq <= slow_clk;
		if (rq && !result_ready_n) begin
			fall_t <= cyc;
			fall_p <= fall_t;
		end
		if (busy) bcnt <= bcnt + 1;
		if (!sq && slow_clk) srise <= srise + 1;
		if (cyc == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Select changes right at the edge, as a synchronous host would
	task automatic drive(input logic v);
		@(posedge core_clk);
		integration_select <= v;
		#1;
	endtask
	task automatic do_reset(input logic v);
		@(posedge core_clk);
		resetn <= 1'b0;
		integration_select <= v;
		step(2);
		@(posedge core_clk);
		resetn <= 1'b1;
		step(1);
	endtask
	task automatic t_power_up;
		do_reset(1'b1);
		chk(state, seq_pkg::ST_MRAZ_A_FIRST);
		do_reset(1'b0);
		chk(state, seq_pkg::ST_MRAZ_B_FIRST);
		chk(gnd, 1'b1);
		step(1);
		chk(state, seq_pkg::ST_PREP_B);
		$display("test power_up done");
	endtask
	task automatic t_gapless;
		int t0, b0, d1;
		do_reset(1'b1);
		step(12);
		chk(state, seq_pkg::ST_INT_A);
		drive(1'b0);
		step(1);
		chk(state, seq_pkg::ST_INT_B_MRAZ_A);
		chk(sb, 1'b1);
		step(80);
		drive(1'b1);
		step(1);
		chk(state, seq_pkg::ST_INT_A_MRAZ_B);
		step(80);
		drive(1'b0);
		t0 = cyc;
		b0 = bcnt;
		step(80);
		d1 = fall_t - t0;
		chk(bcnt - b0, MC);
		chk(slow_clk, 1'b0);
		drive(1'b1);
		t0 = cyc;
		step(80);
		chk(fall_t - t0, d1);
		$display("test gapless done");
	endtask
	task automatic t_gapped;
		int b0, s0;
		drive(1'b0);
		b0 = bcnt;
		// Eighteen clocks, a whole number of half slow periods
		step(17);
		drive(1'b1);
		step(1);
		chk(state, seq_pkg::ST_MRAZ_A_FIRST);
		chk(gnd, 1'b1);
		drive(1'b0);
		step(5);
		chk(state, seq_pkg::ST_MRAZ_A_FIRST);
		for (int i = 0; i < 200 && busy; i++) step(1);
		step(2);
		chk(bcnt - b0, MG);
		chk(fall_t - fall_p, R2);
		s0 = srise;
		step(12);
		chk(srise - s0, 2);
		chk(state, seq_pkg::ST_PREP_A);
		// The sequencer does not time preparation, so the host must
		step(seq_pkg::PREP_MIN_CLKS);
		drive(1'b1);
		step(1);
		chk(state, seq_pkg::ST_INT_A);
		chk(sa, 1'b1);
		$display("test gapped done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		t_power_up();
		t_gapless();
		t_gapped();
		wrap_up();
	end
endmodule // dual_integrator_sequencer_bench
